// file: include/init_if.sv
// Initiator request, window setup and read completion between units
`timescale 1ns/10ps
interface init_if;
  logic req_valid;
  logic [31:0] req_addr;
  logic req_io;
  logic [3:0] win_en;
  logic [3:0][23:0] base;
  logic start;
  logic [1:0] start_win;
  logic [31:0] start_addr;
  logic blocked;
  logic done_valid;
  logic done_read;
  logic [4:0] done_err;
  logic [31:0] done_data;
  logic rbe;
  logic resp_valid;
  logic resp_err;
  logic [31:0] resp_data;
  modport ctl (output req_valid, req_addr, req_io, win_en, base,
    done_valid, done_read, done_err, done_data, rbe,
    input start, start_win, start_addr, blocked,
    resp_valid, resp_err, resp_data);
  modport dec (input req_valid, req_addr, req_io, win_en, base,
    output start, start_win, start_addr, blocked);
  modport rsp (input done_valid, done_read, done_err, done_data, rbe,
    output resp_valid, resp_err, resp_data);
endinterface : init_if

// file: include/pcicfg_defines.svh
// Offsets, field positions, reset values and timing of the config block
`ifndef PCICFG_DEFINES_SVH
`define PCICFG_DEFINES_SVH
`define CFG_OFFSET 16'hd170
`define IRQ_STAT_OFFSET 16'hd180
`define IRQ_MASK_OFFSET 16'hd184
`define WIN_BASE_PAGE 12'hd19
`define SOFT_RESET_CTL_BIT 10
`define RBE_BIT 9
`define WIN0_BIT 8
`define WIN1_BIT 7
`define WIN2_BIT 6
`define IO_BIT 5
`define CONFIG_LOAD_SOURCE_BIT 2
`define SOFT_RESET_CTL_RST 1'b0
`define RBE_RST 1'b1
`define WIN0_RST 1'b0
`define WIN1_RST 1'b0
`define WIN2_NORMAL_RST 1'b0
`define WIN2_BOOT_RST 1'b1
`define IO_RST 1'b0
`define CONFIG_LOAD_SOURCE_RST 1'b0
`define IRQ_W 5
`define IRQ_SOFT_RESET_CTL_DONE 0
`define IRQ_EARLY_CLR 1
`define IRQ_NOT_READY 2
`define IRQ_RD_ERR 3
`define IRQ_BLOCKED 4
`define ERR_W 5
`define BASE_LSB 8
`define STRAP_SETTLE 2'd2
`define SYS_CLK_PERIOD_NS 5
`define PCI_CLK_PERIOD_NS 30
`define SOFT_RESET_CTL_MIN_PCI_CLKS 4
`define SOFT_RESET_CTL_MIN_NS (`SOFT_RESET_CTL_MIN_PCI_CLKS * `PCI_CLK_PERIOD_NS)
`define SOFT_RESET_CTL_MIN_CYCLES \
  ((`SOFT_RESET_CTL_MIN_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)
`endif

// file: include/pcicfg_pkg.sv
// Types shared by the config block and its window and response units
package pcicfg_pkg;
`include "pcicfg_defines.svh"
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_RWAIT = 2'b10,
    BUS_RDONE = 2'b11
  } bus_state_type;
  typedef struct packed {
    bus_state_type bus;
    logic [15:0] addr;
    logic [31:0] rdata;
    logic soft_reset_ctl;
    logic rbe;
    logic [3:0] win_en;
    logic config_load_source;
    logic [3:0][23:0] base;
    logic [`IRQ_W-1:0] irq_stat;
    logic [`IRQ_W-1:0] irq_mask;
    logic irq;
    logic [7:0] soft_reset_ctl_cnt;
    logic reload;
    logic reload_src;
    logic [1:0] boot_sync;
    logic [1:0] done_sync;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic boot_mode;
  } top_state_type;
  typedef struct packed {
    logic start;
    logic [1:0] win;
    logic [31:0] addr;
    logic blocked;
  } dec_state_type;
  typedef struct packed {
    logic valid;
    logic err;
    logic [31:0] data;
  } rsp_state_type;
endpackage : pcicfg_pkg

// file: tb/pci_target_model.sv
// Far-side PCI target: answers each started read after a set delay
`timescale 1ns/10ps
module pci_target_model (
  // Clock
  input wire logic clk_in,
  // Start from the bridge
  input wire logic start_in,
  input wire logic [31:0] addr_in,
  // Behaviour chosen by the bench
  input wire logic [3:0] delay_in,
  input wire logic [4:0] err_in,
  // Completion toward the bridge
  output logic done_valid_out,
  output logic done_read_out,
  output logic [4:0] done_err_out,
  output logic [31:0] done_data_out
);
  logic [4:0] cnt = 5'h00;
  logic [31:0] held = 32'h0;
  logic valid_q = 1'b0;
  logic [4:0] err_q = 5'h00;
  logic [31:0] data_q = 32'h0;
  assign done_valid_out = valid_q;
  assign done_read_out = 1'b1;
  assign done_err_out = err_q;
  assign done_data_out = data_q;
  // Data toggles outside a completion, never holding a stale value
  always @(posedge clk_in) begin
    valid_q <= 1'b0;
    err_q <= 5'h00;
    data_q <= ~data_q;
    if (start_in) begin
      held <= addr_in;
      cnt <= {1'b0, delay_in} + 5'h01;
    end else if (cnt != 5'h00) begin
      cnt <= cnt - 5'h01;
      if (cnt == 5'h01) begin
        valid_q <= 1'b1;
        err_q <= err_in;
        data_q <= ~held;
      end
    end
  end
endmodule : pci_target_model

// file: tb/test_pci_ctrl_softreset_window_enables.sv
// Bench for the controller config block over AHB-Lite
`timescale 1ns/10ps
`include "pcicfg_defines.svh"
module test_pci_ctrl_softreset_window_enables;
  localparam logic [15:0] base_a = {`WIN_BASE_PAGE, 4'h0};
  localparam logic [31:0] rbe_m = 32'h1 << `RBE_BIT;
  localparam logic [31:0] soft_reset_ctl_m = 32'h1 << `SOFT_RESET_CTL_BIT;
  localparam logic [31:0] config_load_source_m = 32'h1 << `CONFIG_LOAD_SOURCE_BIT;
  localparam logic [31:0] w0_m = 32'h1 << `WIN0_BIT;
  localparam logic [31:0] w2_m = 32'h1 << `WIN2_BIT;
  localparam int en_bit [4] = '{`WIN0_BIT, `WIN1_BIT, `WIN2_BIT, `IO_BIT};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic boot = 1'b0;
  logic ee_done = 1'b0;
  logic req_v = 1'b0;
  logic req_io = 1'b0;
  logic [31:0] req_a = 32'h0;
  logic [3:0] pm_delay = 4'h0;
  logic [4:0] pm_err = 5'h00;
  logic hready, hresp, soft_reset_ctl_o, reload, rl_regs, irq, st_v, blk, dv, dr;
  logic rv, re;
  logic [1:0] st_w;
  logic [4:0] de;
  logic [31:0] hrdata, st_a, dd, rd;
  int err_total = 0;
  int checks = 0;
  always #2.5 clk = ~clk;
  pcicfg_top uut (.SYS_CLK_IN(clk), .RESETN_IN(rst_n), .HSEL_IN(hsel),
    .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
    .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready),
    .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .BOOT_MODE_IN(boot), .EEPROM_LOAD_DONE_IN(ee_done),
    .SOFT_RESET_OUT(soft_reset_ctl_o), .RELOAD_OUT(reload),
    .RELOAD_FROM_REGS_OUT(rl_regs), .IRQ_OUT(irq),
    .INIT_REQ_VALID_IN(req_v), .INIT_REQ_ADDR_IN(req_a),
    .INIT_REQ_IO_IN(req_io), .START_VALID_OUT(st_v), .START_WIN_OUT(st_w),
    .START_ADDR_OUT(st_a), .BLOCKED_OUT(blk), .DONE_VALID_IN(dv),
    .DONE_READ_IN(dr), .DONE_ERR_IN(de), .DONE_DATA_IN(dd),
    .RESP_VALID_OUT(rv), .RESP_ERR_OUT(re), .RESP_DATA_OUT(rd));
  pci_target_model pm (.clk_in(clk), .start_in(st_v), .addr_in(st_a),
    .delay_in(pm_delay), .err_in(pm_err), .done_valid_out(dv),
    .done_read_out(dr), .done_err_out(de), .done_data_out(dd));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Bounded wait for ready, response, reload or interrupt
  task automatic wait_hi(input int which);
    int n;
    logic s;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      s = (which == 0) ? hready : (which == 1) ? rv :
        (which == 2) ? reload : irq;
    end while (s !== 1'b1 && n < 64);
    if (s !== 1'b1) begin
      err_total++;
      give_verdict();
    end
  endtask : wait_hi

  task automatic bus_wr(input logic [15:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= 1'b1;
    haddr <= {16'h0000, a};
    wait_hi(0);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_hi(0);
  endtask : bus_wr

  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp,
      input string what);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= 1'b0;
    haddr <= {16'h0000, a};
    wait_hi(0);
    hsel <= 1'b0;
    htrans <= 2'h0;
    wait_hi(0);
    chk(what, exp, hrdata);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : rd_chk

  // Expected code: start, blocked, window
  task automatic init_req(input logic [31:0] a, input logic io,
      input logic [3:0] exp);
    req_v <= 1'b1;
    req_a <= a;
    req_io <= io;
    @(posedge clk);
    req_v <= 1'b0;
    @(posedge clk);
    chk("start", {28'h0, exp}, {28'h0, st_v, blk, st_v ? st_w : 2'h0});
    if (exp[3]) chk("start addr", a, st_a);
  endtask : init_req

  task automatic done_test(input string t);
    $display("test %s finished, mismatches %0d", t, err_total);
  endtask : done_test

  initial begin
    logic [31:0] cfg;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    ee_done <= 1'b1;
    repeat (5) @(posedge clk);
    rd_chk(`CFG_OFFSET, rbe_m, "config reset");
    rd_chk(`IRQ_STAT_OFFSET, 32'h0, "status reset");
    bus_wr(16'hd1a0, 32'hffff_ffff);
    rd_chk(16'hd1a0, 32'h0, "unmapped");
    done_test("reset values");
    for (int i = 0; i < 4; i++) begin
      bus_wr(base_a + 16'(4 * i), {4'(i + 1), 28'h00000ff});
      rd_chk(base_a + 16'(4 * i), {4'(i + 1), 28'h0}, "base");
    end
    for (int i = 0; i < 4; i++) begin
      cfg = rbe_m | (32'h1 << en_bit[i]);
      bus_wr(`CFG_OFFSET, cfg);
      rd_chk(`CFG_OFFSET, cfg, "enables");
      for (int j = 0; j < 4; j++) begin
        init_req({4'(j + 1), 28'h0000040}, j == 3,
          (i == j) ? {2'b10, 2'(j)} : 4'b0100);
      end
    end
    rd_chk(`IRQ_STAT_OFFSET, 32'h1 << `IRQ_BLOCKED, "blocked status");
    init_req(32'h1000_0000, 1'b0, 4'b0100);
    repeat (3) @(posedge clk);
    chk("masked irq", 32'h0, {31'h0, irq});
    bus_wr(`IRQ_MASK_OFFSET, 32'h1 << `IRQ_BLOCKED);
    wait_hi(3);
    rd_chk(`IRQ_STAT_OFFSET, 32'h1 << `IRQ_BLOCKED, "irq status");
    @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    done_test("windows and interrupt");
    bus_wr(`CFG_OFFSET, rbe_m | w0_m);
    for (int k = 0; k < 6; k++) begin
      pm_err <= (k < 5) ? 5'h01 << k : 5'h00;
      pm_delay <= 4'(k);
      init_req(32'h1000_0080, 1'b0, 4'b1000);
      wait_hi(1);
      chk("bus error", {31'h0, k < 5}, {31'h0, re});
      chk("read data", (k < 5) ? 32'h0 : ~32'h1000_0080, rd);
    end
    bus_wr(`CFG_OFFSET, w0_m);
    pm_err <= 5'h04;
    init_req(32'h1000_0100, 1'b0, 4'b1000);
    wait_hi(1);
    chk("no bus error", 32'h0, {31'h0, re});
    chk("data passed", ~32'h1000_0100, rd);
    rd_chk(`IRQ_STAT_OFFSET, 32'h1 << `IRQ_RD_ERR, "error status");
    pm_err <= 5'h00;
    done_test("read error response");
    bus_wr(`CFG_OFFSET, rbe_m | config_load_source_m | w0_m);
    bus_wr(`IRQ_MASK_OFFSET, 32'h1 << `IRQ_SOFT_RESET_CTL_DONE);
    bus_wr(base_a, 32'h1230_0000);
    init_req(32'h2000_0000, 1'b0, 4'b0100);
    bus_wr(`CFG_OFFSET, soft_reset_ctl_m | w0_m);
    wait_hi(2);
    chk("reload source", 32'h1, {31'h0, rl_regs});
    chk("soft reset", 32'h1, {31'h0, soft_reset_ctl_o});
    rd_chk(`IRQ_MASK_OFFSET, 32'h0, "locked mask");
    bus_wr(base_a, 32'h5550_0000);
    rd_chk(`CFG_OFFSET, soft_reset_ctl_m | rbe_m | config_load_source_m, "config held");
    repeat (`SOFT_RESET_CTL_MIN_CYCLES) @(posedge clk);
    chk("reset irq", 32'h1, {31'h0, irq});
    bus_wr(`CFG_OFFSET, rbe_m | config_load_source_m);
    rd_chk(`CFG_OFFSET, rbe_m | config_load_source_m, "config after");
    rd_chk(base_a, 32'h0, "base after");
    rd_chk(`IRQ_MASK_OFFSET, 32'h1 << `IRQ_SOFT_RESET_CTL_DONE, "mask after");
    rd_chk(`IRQ_STAT_OFFSET, (32'h1 << `IRQ_SOFT_RESET_CTL_DONE) |
      (32'h1 << `IRQ_BLOCKED), "status kept");
    done_test("soft reset");
    rst_n <= 1'b0;
    boot <= 1'b1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    rd_chk(`CFG_OFFSET, rbe_m | w2_m, "boot config");
    done_test("boot mode");
    give_verdict();
  end
endmodule : test_pci_ctrl_softreset_window_enables

// file: verilog/pcicfg_top.sv
// Controller config register: soft reset, read error mode, windows
// What this block does
// (RULE1) Setting soft reset reloads configuration space
// (RULE2) Software sets soft reset after EEPROM done
// (RULE3) Software clears soft reset after four PCI clocks
// (RULE4) Other registers locked while soft reset set
// (RULE5) Soft reset keeps status and load source
// (RULE6) Enabled: failed initiator read gives bus error
// (RULE7) Disabled: failed read completes, data invalid
// (RULE8) Bit 8 enables memory window 0
// (RULE9) Bit 7 enables memory window 1
// (RULE10) Bit 6 enables window 2, boot default one
// (RULE11) Bit 5 enables the I/O window
// (RULE12) Window bases in 256-byte units, enable-gated
// (RULE13) Load source picks registers or EEPROM
// (RULE14) Disabled window starts no PCI transaction
`timescale 1ns/10ps
module pcicfg_top import pcicfg_pkg::*; #(
  parameter int WIN_SIZE_LOG2 = 20
) (
  // Clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RESETN_IN,
  // AHB-Lite slave
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  // Pins from outside the clock domain
  input wire logic BOOT_MODE_IN,
  input wire logic EEPROM_LOAD_DONE_IN,
  // Controller reset and reload
  output logic SOFT_RESET_OUT,
  output logic RELOAD_OUT,
  output logic RELOAD_FROM_REGS_OUT,
  output logic IRQ_OUT,
  // Initiator requests from the system bus
  input wire logic INIT_REQ_VALID_IN,
  input wire logic [31:0] INIT_REQ_ADDR_IN,
  input wire logic INIT_REQ_IO_IN,
  output logic START_VALID_OUT,
  output logic [1:0] START_WIN_OUT,
  output logic [31:0] START_ADDR_OUT,
  output logic BLOCKED_OUT,
  // PCI read completions
  input wire logic DONE_VALID_IN,
  input wire logic DONE_READ_IN,
  input wire logic [`ERR_W-1:0] DONE_ERR_IN,
  input wire logic [31:0] DONE_DATA_IN,
  output logic RESP_VALID_OUT,
  output logic RESP_ERR_OUT,
  output logic [31:0] RESP_DATA_OUT
);
  localparam logic [7:0] SOFT_RESET_CTL_MIN = 8'(`SOFT_RESET_CTL_MIN_CYCLES);

  top_state_type st_ff;
  top_state_type nxt_st;
  logic [`IRQ_W-1:0] ev;
  logic clr;
  logic [31:0] rd_val;
  logic new_soft_reset_ctl;
  init_if ifc ();

  if (`SOFT_RESET_CTL_MIN_CYCLES < 1 || `SOFT_RESET_CTL_MIN_CYCLES > 255) begin : g_bad
    $error("pcicfg_top: soft reset hold count does not fit");
  end

  function automatic logic base_sel(input logic [15:0] a);
    return a[15:4] == `WIN_BASE_PAGE;
  endfunction : base_sel

  function automatic logic [31:0] cfg_word(input top_state_type s);
    logic [31:0] v;
    v = 32'h0;
    v[`SOFT_RESET_CTL_BIT] = s.soft_reset_ctl;
    v[`RBE_BIT] = s.rbe;
    v[`WIN0_BIT] = s.win_en[0];
    v[`WIN1_BIT] = s.win_en[1];
    v[`WIN2_BIT] = s.win_en[2];
    v[`IO_BIT] = s.win_en[3];
    v[`CONFIG_LOAD_SOURCE_BIT] = s.config_load_source;
    return v;
  endfunction : cfg_word

  // Read data of the addressed register
  always_comb begin
    rd_val = 32'h0;
    clr = 1'b0;
    if (st_ff.addr == `CFG_OFFSET) begin
      rd_val = cfg_word(st_ff);
    end else if (st_ff.soft_reset_ctl) begin
      rd_val = 32'h0; // RULE4
    end else if (st_ff.addr == `IRQ_STAT_OFFSET) begin
      rd_val = {{(32-`IRQ_W){1'b0}}, st_ff.irq_stat};
      clr = (st_ff.bus == BUS_RWAIT);
    end else if (st_ff.addr == `IRQ_MASK_OFFSET) begin
      rd_val = {{(32-`IRQ_W){1'b0}}, st_ff.irq_mask};
    end else if (base_sel(st_ff.addr)) begin
      rd_val = {st_ff.base[st_ff.addr[3:2]], 8'h00};
    end
  end

  assign new_soft_reset_ctl = HWDATA_IN[`SOFT_RESET_CTL_BIT];

  always_comb begin
    nxt_st = st_ff;
    ev = '0;
    nxt_st.boot_sync = {st_ff.boot_sync[0], BOOT_MODE_IN};
    nxt_st.done_sync = {st_ff.done_sync[0], EEPROM_LOAD_DONE_IN};
    nxt_st.reload = 1'b0;
    // Minimum soft reset hold time
    if (st_ff.soft_reset_ctl && st_ff.soft_reset_ctl_cnt != SOFT_RESET_CTL_MIN) begin
      nxt_st.soft_reset_ctl_cnt = st_ff.soft_reset_ctl_cnt + 8'h01; // RULE3
      if (st_ff.soft_reset_ctl_cnt == SOFT_RESET_CTL_MIN - 8'h01) begin
        ev[`IRQ_SOFT_RESET_CTL_DONE] = 1'b1;
      end
    end
    case (st_ff.bus)
      BUS_WRITE: begin
        nxt_st.bus = BUS_IDLE;
        if (st_ff.addr == `CFG_OFFSET) begin
          if (new_soft_reset_ctl && !st_ff.soft_reset_ctl) begin
            nxt_st.soft_reset_ctl = 1'b1; // RULE1
            nxt_st.soft_reset_ctl_cnt = 8'h00;
            nxt_st.reload = 1'b1; // RULE1
            nxt_st.reload_src = st_ff.config_load_source; // RULE13
            nxt_st.rbe = `RBE_RST;
            nxt_st.win_en[0] = `WIN0_RST;
            nxt_st.win_en[1] = `WIN1_RST;
            nxt_st.win_en[2] = st_ff.boot_mode ? `WIN2_BOOT_RST :
              `WIN2_NORMAL_RST;
            nxt_st.win_en[3] = `IO_RST;
            nxt_st.base = '0;
            // Status, mask and load source survive
            if (!st_ff.done_sync[1]) begin
              ev[`IRQ_NOT_READY] = 1'b1; // RULE2
            end
          end else if (st_ff.soft_reset_ctl) begin
            if (!new_soft_reset_ctl) begin
              nxt_st.soft_reset_ctl = 1'b0; // RULE3
              if (st_ff.soft_reset_ctl_cnt != SOFT_RESET_CTL_MIN) begin
                ev[`IRQ_EARLY_CLR] = 1'b1; // RULE3
              end
            end
          end else begin
            nxt_st.rbe = HWDATA_IN[`RBE_BIT]; // RULE6
            nxt_st.win_en[0] = HWDATA_IN[`WIN0_BIT]; // RULE8
            nxt_st.win_en[1] = HWDATA_IN[`WIN1_BIT]; // RULE9
            nxt_st.win_en[2] = HWDATA_IN[`WIN2_BIT]; // RULE10
            nxt_st.win_en[3] = HWDATA_IN[`IO_BIT]; // RULE11
            nxt_st.config_load_source = HWDATA_IN[`CONFIG_LOAD_SOURCE_BIT]; // RULE13
          end
        end else if (st_ff.soft_reset_ctl) begin
          nxt_st.bus = BUS_IDLE; // RULE4
        end else if (st_ff.addr == `IRQ_MASK_OFFSET) begin
          nxt_st.irq_mask = HWDATA_IN[`IRQ_W-1:0];
        end else if (base_sel(st_ff.addr)) begin
          nxt_st.base[st_ff.addr[3:2]] = HWDATA_IN[31:8]; // RULE12
        end
      end
      BUS_RWAIT: begin
        nxt_st.rdata = rd_val;
        nxt_st.bus = BUS_RDONE;
      end
      default: begin
        nxt_st.bus = BUS_IDLE;
      end
    endcase
    // Address phase
    if (HSEL_IN && HTRANS_IN[1] && HREADY_IN) begin
      nxt_st.addr = HADDR_IN[15:0];
      nxt_st.bus = HWRITE_IN ? BUS_WRITE : BUS_RWAIT;
    end
    // Boot strap picks the window 2 default once settled
    if (!st_ff.strap_done) begin
      if (st_ff.strap_cnt == `STRAP_SETTLE) begin
        nxt_st.strap_done = 1'b1;
        nxt_st.boot_mode = st_ff.boot_sync[1];
        nxt_st.win_en[2] = st_ff.boot_sync[1]; // RULE10
      end else begin
        nxt_st.strap_cnt = st_ff.strap_cnt + 2'h1;
      end
    end
    ev[`IRQ_RD_ERR] = ifc.resp_valid && ifc.resp_err;
    ev[`IRQ_BLOCKED] = ifc.blocked;
    // Hardware set wins over read clear
    nxt_st.irq_stat = (clr ? '0 : st_ff.irq_stat) | ev;
    nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);
    if (!RESETN_IN) begin
      nxt_st = '0;
      nxt_st.soft_reset_ctl = `SOFT_RESET_CTL_RST;
      nxt_st.rbe = `RBE_RST; // RULE6
      nxt_st.win_en[0] = `WIN0_RST; // RULE8
      nxt_st.win_en[1] = `WIN1_RST; // RULE9
      nxt_st.win_en[2] = `WIN2_NORMAL_RST; // RULE10
      nxt_st.win_en[3] = `IO_RST; // RULE11
      nxt_st.config_load_source = `CONFIG_LOAD_SOURCE_RST;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    st_ff <= nxt_st;
  end

  // Unit wiring
  assign ifc.req_valid = INIT_REQ_VALID_IN;
  assign ifc.req_addr = INIT_REQ_ADDR_IN;
  assign ifc.req_io = INIT_REQ_IO_IN;
  assign ifc.win_en = st_ff.win_en;
  assign ifc.base = st_ff.base;
  assign ifc.done_valid = DONE_VALID_IN;
  assign ifc.done_read = DONE_READ_IN;
  assign ifc.done_err = DONE_ERR_IN;
  assign ifc.done_data = DONE_DATA_IN;
  assign ifc.rbe = st_ff.rbe;

  win_decode #(
    .WIN_SIZE_LOG2(WIN_SIZE_LOG2)
  ) u_win_decode (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RESETN_IN),
    .ifc(ifc.dec)
  );

  read_resp u_read_resp (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RESETN_IN),
    .ifc(ifc.rsp)
  );

  // Outputs
  assign HRDATA_OUT = st_ff.rdata;
  assign HREADYOUT_OUT = (st_ff.bus != BUS_RWAIT);
  assign HRESP_OUT = 1'b0;
  assign SOFT_RESET_OUT = st_ff.soft_reset_ctl;
  assign RELOAD_OUT = st_ff.reload;
  assign RELOAD_FROM_REGS_OUT = st_ff.reload_src;
  assign IRQ_OUT = st_ff.irq;
  assign START_VALID_OUT = ifc.start;
  assign START_WIN_OUT = ifc.start_win;
  assign START_ADDR_OUT = ifc.start_addr;
  assign BLOCKED_OUT = ifc.blocked;
  assign RESP_VALID_OUT = ifc.resp_valid;
  assign RESP_ERR_OUT = ifc.resp_err;
  assign RESP_DATA_OUT = ifc.resp_data;

  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  a_soft_reset_ctl_reload: assert property ( // RULE1 RULE13
    $rose(st_ff.soft_reset_ctl) |-> st_ff.reload &&
      st_ff.reload_src == $past(st_ff.config_load_source))
    else $error("soft reset without reload");
  a_soft_reset_ctl_defaults: assert property ( // RULE1
    $rose(st_ff.soft_reset_ctl) |-> st_ff.rbe && st_ff.win_en[1:0] == 2'b00 &&
      !st_ff.win_en[3] && st_ff.base == '0)
    else $error("soft reset left configuration");
  a_regs_locked: assert property ( // RULE4
    st_ff.bus == BUS_WRITE && st_ff.soft_reset_ctl &&
      st_ff.addr != `CFG_OFFSET |=> $stable(st_ff.base) &&
      $stable(st_ff.irq_mask))
    else $error("register written during soft reset");
  a_reads_locked: assert property ( // RULE4
    st_ff.bus == BUS_RWAIT && st_ff.soft_reset_ctl &&
      st_ff.addr != `CFG_OFFSET |=> st_ff.rdata == 32'h0)
    else $error("register read during soft reset");
  a_status_kept: assert property ( // RULE5
    $rose(st_ff.soft_reset_ctl) |-> st_ff.config_load_source == $past(st_ff.config_load_source) &&
      (st_ff.irq_stat & $past(st_ff.irq_stat)) ==
      $past(st_ff.irq_stat) && st_ff.irq_mask == $past(st_ff.irq_mask))
    else $error("soft reset disturbed status");
  a_reset_values: assert property ( // RULE8 RULE9 RULE11
    @(posedge SYS_CLK_IN) disable iff (1'b0)
    !RESETN_IN |=> st_ff.rbe && st_ff.win_en == 4'h0 && !st_ff.soft_reset_ctl)
    else $error("wrong reset values");
  a_strap_load: assert property ( // RULE10
    !st_ff.strap_done && st_ff.strap_cnt == `STRAP_SETTLE |=>
      st_ff.win_en[2] == $past(st_ff.boot_sync[1]) && st_ff.strap_done)
    else $error("boot default of window 2 lost");
  a_cfg_write: assert property ( // RULE8 RULE9 RULE10 RULE11
    st_ff.bus == BUS_WRITE && st_ff.addr == `CFG_OFFSET &&
      !st_ff.soft_reset_ctl && !new_soft_reset_ctl && st_ff.strap_done |=>
      st_ff.win_en == $past({HWDATA_IN[`IO_BIT], HWDATA_IN[`WIN2_BIT],
      HWDATA_IN[`WIN1_BIT], HWDATA_IN[`WIN0_BIT]}) &&
      st_ff.rbe == $past(HWDATA_IN[`RBE_BIT]))
    else $error("config write did not take");
  a_hold_count: assert property ( // RULE3
    $rose(st_ff.soft_reset_ctl) ##1 st_ff.soft_reset_ctl [*4] |-> st_ff.soft_reset_ctl_cnt == 8'h04)
    else $error("soft reset hold count off");

  c_soft_reset: cover property ($rose(st_ff.soft_reset_ctl) ##[1:40] !st_ff.soft_reset_ctl);
  c_read_error: cover property (ev[`IRQ_RD_ERR]);
  c_irq: cover property ($rose(st_ff.irq));
endmodule : pcicfg_top

// file: verilog/read_resp.sv
// Read completion toward the system bus with optional bus error
`timescale 1ns/10ps
module read_resp import pcicfg_pkg::*; (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Completions and answers
  init_if.rsp ifc
);
  rsp_state_type st_ff;
  rsp_state_type nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.valid = ifc.done_valid;
    if (ifc.done_valid) begin
      if (ifc.done_read && |ifc.done_err && ifc.rbe) begin
        nxt_st.err = 1'b1; // RULE6
        nxt_st.data = 32'h0;
      end else begin
        nxt_st.err = 1'b0; // RULE7
        nxt_st.data = ifc.done_data;
      end
    end
    if (!rst_n_in) nxt_st = '0;
  end

  always_ff @(posedge clk_in) begin
    st_ff <= nxt_st;
  end

  assign ifc.resp_valid = st_ff.valid;
  assign ifc.resp_err = st_ff.err;
  assign ifc.resp_data = st_ff.data;

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_rd_bus_error: assert property ( // RULE6
    ifc.done_valid && ifc.done_read && |ifc.done_err && ifc.rbe
    |=> st_ff.valid && st_ff.err)
    else $error("failed read not answered with bus error");
  a_rd_normal_end: assert property ( // RULE7
    ifc.done_valid && !ifc.rbe |=> st_ff.valid && !st_ff.err &&
      st_ff.data == $past(ifc.done_data))
    else $error("failed read not completed normally");
  c_bus_error: cover property (st_ff.valid && st_ff.err);
endmodule : read_resp

// file: verilog/win_decode.sv
// Initiator window decode gated by the window enables
`timescale 1ns/10ps
module win_decode import pcicfg_pkg::*; #(
  parameter int WIN_SIZE_LOG2 = 20
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Window setup and requests
  init_if.dec ifc
);
  dec_state_type st_ff;
  dec_state_type nxt_st;
  logic [3:0] hit;
  logic [3:0] cand;
  logic [3:0] ok_hit;

  if (WIN_SIZE_LOG2 < `BASE_LSB || WIN_SIZE_LOG2 > 31) begin : g_bad
    $error("win_decode: WIN_SIZE_LOG2 out of range");
  end

  // Base compare at 2^WIN_SIZE_LOG2-byte granularity
  for (genvar i = 0; i < 4; i++) begin : g_hit
    assign hit[i] = ifc.req_addr[31:WIN_SIZE_LOG2] ==
      ifc.base[i][23:WIN_SIZE_LOG2-`BASE_LSB]; // RULE12
  end
  assign cand = hit & (ifc.req_io ? 4'h8 : 4'h7);
  assign ok_hit = cand & ifc.win_en; // RULE14

  always_comb begin
    nxt_st = st_ff;
    nxt_st.start = 1'b0;
    nxt_st.blocked = 1'b0;
    if (ifc.req_valid && |ok_hit) begin
      nxt_st.start = 1'b1;
      nxt_st.addr = ifc.req_addr;
      if (ok_hit[0]) nxt_st.win = 2'h0;
      else if (ok_hit[1]) nxt_st.win = 2'h1;
      else if (ok_hit[2]) nxt_st.win = 2'h2;
      else nxt_st.win = 2'h3;
    end else if (ifc.req_valid && |cand) begin
      nxt_st.blocked = 1'b1; // RULE14
    end
    if (!rst_n_in) nxt_st = '0;
  end

  always_ff @(posedge clk_in) begin
    st_ff <= nxt_st;
  end

  assign ifc.start = st_ff.start;
  assign ifc.start_win = st_ff.win;
  assign ifc.start_addr = st_ff.addr;
  assign ifc.blocked = st_ff.blocked;

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_no_disabled_start: assert property ( // RULE14
    ifc.req_valid && !(|ok_hit) |=> !st_ff.start)
    else $error("start through a disabled window");
  a_start_window_addr: assert property ( // RULE12
    ifc.req_valid && |ok_hit |=> st_ff.start &&
      st_ff.addr == $past(ifc.req_addr) && ifc.win_en[st_ff.win] |
      !$stable(ifc.win_en))
    else $error("enabled window hit did not start");
  c_io_start: cover property (st_ff.start && st_ff.win == 2'h3);
endmodule : win_decode
